/* File: rtl/aopfm_pkg.sv */
package aopfm_pkg;

  // register map and widths
  localparam int          REG_ADDR_W     = 9;
  localparam int          REG_DATA_W     = 16;
  localparam logic [8:0]  FLAG_DIR_ADDR  = 9'h1c1;
  localparam logic [8:0]  FLAG_ORIG_ADDR = 9'h1c3;
  localparam logic [15:0] FLAG_DIR_RST   = 16'h0000;
  localparam logic [15:0] FLAG_ORIG_RST  = 16'h0000;
  localparam logic [15:0] REG_RD_NONE    = 16'h0000;

  // flag bus bit served by each pin
  localparam int PIN_COUNT  = 2;
  localparam int FLAG_BIT_0 = 10;
  localparam int FLAG_BIT_1 = 11;

  // control reset values and gain codes
  localparam logic       CTRL_RST   = 1'b0;
  localparam int         GAIN_W     = 2;
  localparam logic [1:0] GAIN_RST   = 2'h0;
  localparam logic [1:0] GAIN_3V3   = 2'h0;
  localparam logic [1:0] GAIN_5V0   = 2'h1;
  localparam logic [1:0] GAIN_2P0   = 2'h2;
  localparam logic [1:0] GAIN_5P33  = 2'h3;

  // per pin configuration seen by the decoder
  typedef struct packed {
    logic origin;
    logic direction;
    logic functionSelect;
    logic ampEnable;
    logic driveEnable;
    logic flagDrive;
  } aopfm_pin_cfg_type;

  // per pin decoded state
  typedef struct packed {
    logic bufferOn;
    logic routeDigital;
    logic padLevel;
    logic digitalInput;
    logic flagDirIn;
    logic ampHiZ;
  } aopfm_pin_state_type;

endpackage : aopfm_pkg

/* File: rtl/aopfm_pin_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module aopfm_pin_decode
(
  // configuration of one pin
  input  wire aopfm_pkg::aopfm_pin_cfg_type   cfg,
  // decoded pin state
  output var aopfm_pkg::aopfm_pin_state_type  state
);
  import aopfm_pkg::*;

  logic analogMode;
  logic digIn;
  logic digOut;

  // truth table decode of one pin
  always_comb
  begin
    analogMode = !cfg.origin && !cfg.functionSelect;
    digIn      = cfg.origin && cfg.direction;
    digOut     = cfg.origin && !cfg.direction && cfg.functionSelect
                 && cfg.driveEnable;
    state              = '0;
    state.routeDigital = cfg.functionSelect;          // [RULE8]
    state.padLevel     = cfg.flagDrive;               // [RULE8]
    state.digitalInput = digIn && cfg.functionSelect
                         && !cfg.driveEnable;         // [RULE6]
    if (digIn)
      state.bufferOn = 1'b0;                          // [RULE3] [RULE6]
    else if (analogMode)
      state.bufferOn = cfg.ampEnable;                 // [RULE4] [RULE5]
    else if (digOut)
      state.bufferOn = 1'b1;                          // [RULE7]
    else
      state.bufferOn = 1'b0;                          // [RULE12]
    state.flagDirIn = digOut;                         // [RULE9]
    state.ampHiZ    = cfg.functionSelect
                      || !state.bufferOn;             // [RULE9]
  end

endmodule : aopfm_pin_decode
`default_nettype wire

/* File: rtl/aopfm_top.sv */
// Function
// [RULE1] both pins serve flag bits 10 and 11
// [RULE2] flag registers written by host select function
// [RULE3] digital input forces buffer high impedance
// [RULE4] analog mode, enable low: buffer off
// [RULE5] analog mode, enable high: buffer on
// [RULE6] origin1 dir1 sel1 drive0: digital input
// [RULE7] origin1 dir0 sel1 drive1: digital output
// [RULE8] select 0 routes analog, 1 flag drive
// [RULE9] digital output: flag internal input, amplifier off
// [RULE10] gain code sets digital output level
// [RULE11] host picks gain matching its interface
// [RULE12] undocumented combinations keep buffer off
`timescale 1ns/10ps
`default_nettype none
module aopfm_top
(
  // clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              rst,
  // register access port
  input  wire logic                              regWrite,
  input  wire logic                              regRead,
  input  wire logic [aopfm_pkg::REG_ADDR_W-1:0]  regAddr,
  input  wire logic [aopfm_pkg::REG_DATA_W-1:0]  regWrData,
  output logic      [aopfm_pkg::REG_DATA_W-1:0]  regRdData,
  output logic                                   regRdValid,
  // per pin controls from the digital cores
  input  wire logic [1:0]                        pinFunctionSelect,
  input  wire logic [1:0]                        amplifierOutputEnable,
  input  wire logic [1:0]                        pinDriveEnable,
  input  wire logic [1:0]                        flagDriveSignal,
  input  wire logic [3:0]                        gainCode,
  // the two pads
  input  wire logic                              firstSenseOutPinIn,
  output logic                                   firstSenseOutPinOut,
  output logic                                   firstSenseOutPinOeN,
  input  wire logic                              secondSenseOutPinIn,
  output logic                                   secondSenseOutPinOut,
  output logic                                   secondSenseOutPinOeN,
  // status towards core and analog path
  output logic [1:0]                             flagIn,
  output logic [1:0]                             flagInValid,
  output logic [1:0]                             flagDirIn,
  output logic [1:0]                             routeDigital,
  output logic [1:0]                             ampHiZ,
  output logic [3:0]                             ampGainCode
);
  import aopfm_pkg::*;

  logic [15:0]         flagDir_q, flagDir_d;
  logic [15:0]         flagOrig_q, flagOrig_d;
  logic [15:0]         rdData_q, rdData_d;
  logic                rdValid_q, rdValid_d;
  logic [1:0]          sync1_q, sync2_q, sync3_q;
  logic [1:0]          padIn;
  logic [1:0]          filt_q, filt_d;
  aopfm_pin_cfg_type   pinCfg [PIN_COUNT];
  aopfm_pin_state_type pinState [PIN_COUNT];
  logic [1:0]          oeN_q, oeN_d;
  logic [1:0]          out_q, out_d;
  logic [1:0]          flagIn_q, flagIn_d;
  logic [1:0]          flagVal_q, flagVal_d;
  logic [1:0]          dirIn_q, dirIn_d;
  logic [1:0]          route_q, route_d;
  logic [1:0]          hiz_q, hiz_d;
  logic [3:0]          gain_q, gain_d;

  // register write and read decode
  always_comb
  begin
    flagDir_d  = flagDir_q;
    flagOrig_d = flagOrig_q;
    rdData_d   = rdData_q;
    rdValid_d  = regRead;
    if (regWrite && regAddr == FLAG_DIR_ADDR)
      flagDir_d = regWrData;                          // [RULE2]
    if (regWrite && regAddr == FLAG_ORIG_ADDR)
      flagOrig_d = regWrData;                         // [RULE2]
    if (regRead)
    begin
      unique case (regAddr)
        FLAG_DIR_ADDR:  rdData_d = flagDir_q;
        FLAG_ORIG_ADDR: rdData_d = flagOrig_q;
        default:        rdData_d = REG_RD_NONE;
      endcase
    end
  end

  // register storage
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      flagDir_q  <= FLAG_DIR_RST;
      flagOrig_q <= FLAG_ORIG_RST;
      rdData_q   <= REG_RD_NONE;
      rdValid_q  <= CTRL_RST;
    end
    else
    begin
      flagDir_q  <= flagDir_d;
      flagOrig_q <= flagOrig_d;
      rdData_q   <= rdData_d;
      rdValid_q  <= rdValid_d;
    end
  end

  // pad input filter: accept when stages two and three agree
  assign padIn = {secondSenseOutPinIn, firstSenseOutPinIn};

  always_comb
  begin
    filt_d = filt_q;
    for (int i = 0; i < PIN_COUNT; i++)
      if (sync2_q[i] == sync3_q[i])
        filt_d[i] = sync3_q[i];
  end

  // input synchroniser chain
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      sync3_q <= 2'h0;
      filt_q  <= 2'h0;
    end
    else
    begin
      sync1_q <= padIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= filt_d;
    end
  end

  // per pin configuration: origin and direction from flag bits 10 and 11, the rest from core controls
  always_comb
  begin
    pinCfg[0].origin    = flagOrig_q[FLAG_BIT_0];     // [RULE1]
    pinCfg[0].direction = flagDir_q[FLAG_BIT_0];      // [RULE1]
    pinCfg[1].origin    = flagOrig_q[FLAG_BIT_1];     // [RULE1]
    pinCfg[1].direction = flagDir_q[FLAG_BIT_1];      // [RULE1]
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      pinCfg[i].functionSelect = pinFunctionSelect[i];
      pinCfg[i].ampEnable      = amplifierOutputEnable[i];
      pinCfg[i].driveEnable    = pinDriveEnable[i];
      pinCfg[i].flagDrive      = flagDriveSignal[i];
    end
  end

  // one decoder per pin
  generate
    for (genvar g = 0; g < PIN_COUNT; g++)
    begin : gPin
      aopfm_pin_decode uDecode
      (
        .cfg   (pinCfg[g]),
        .state (pinState[g])
      );
    end
  endgenerate

  // pad and status next values
  always_comb
  begin
    flagIn_d = flagIn_q;
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      oeN_d[i]     = !pinState[i].bufferOn;           // [RULE3] [RULE12]
      out_d[i]     = pinState[i].bufferOn
                     && pinState[i].routeDigital
                     && pinState[i].padLevel;         // [RULE7] [RULE8]
      flagVal_d[i] = pinState[i].digitalInput;        // [RULE6]
      if (pinState[i].digitalInput)
        flagIn_d[i] = filt_q[i];                      // [RULE6]
      dirIn_d[i]   = pinState[i].flagDirIn;           // [RULE9]
      route_d[i]   = pinState[i].routeDigital;        // [RULE8]
      hiz_d[i]     = pinState[i].ampHiZ;              // [RULE9]
    end
    gain_d = gainCode;                                // [RULE10]
  end

  // pad and status registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      oeN_q     <= 2'h3;
      out_q     <= 2'h0;
      flagIn_q  <= 2'h0;
      flagVal_q <= 2'h0;
      dirIn_q   <= 2'h0;
      route_q   <= 2'h0;
      hiz_q     <= 2'h3;
      gain_q    <= {GAIN_RST, GAIN_RST};
    end
    else
    begin
      oeN_q     <= oeN_d;
      out_q     <= out_d;
      flagIn_q  <= flagIn_d;
      flagVal_q <= flagVal_d;
      dirIn_q   <= dirIn_d;
      route_q   <= route_d;
      hiz_q     <= hiz_d;
      gain_q    <= gain_d;
    end
  end

  // outputs straight from flops
  assign regRdData            = rdData_q;
  assign regRdValid           = rdValid_q;
  assign firstSenseOutPinOut  = out_q[0];
  assign firstSenseOutPinOeN  = oeN_q[0];
  assign secondSenseOutPinOut = out_q[1];
  assign secondSenseOutPinOeN = oeN_q[1];
  assign flagIn               = flagIn_q;
  assign flagInValid          = flagVal_q;
  assign flagDirIn            = dirIn_q;
  assign routeDigital         = route_q;
  assign ampHiZ               = hiz_q;
  assign ampGainCode          = gain_q;

endmodule : aopfm_top
`default_nettype wire

/* File: verification/aopfm_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module aopfm_properties
(
  // clock, reset, host port
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       regRead,
  input wire logic       regRdValid,
  // pin controls and status
  input wire logic [1:0] pinFunctionSelect,
  input wire logic [1:0] amplifierOutputEnable,
  input wire logic [1:0] pinDriveEnable,
  input wire logic [3:0] gainCode,
  input wire logic       firstSenseOutPinOeN,
  input wire logic [1:0] flagDirIn,
  input wire logic [1:0] routeDigital,
  input wire logic [1:0] ampHiZ,
  input wire logic [3:0] ampGainCode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // read answered one cycle after its strobe
  sequence rd_ans_s;
    ##1 regRdValid;
  endsequence
  rd_answer_a: assert property (regRead |-> rd_ans_s)
    else $error("read not answered");
  rd_stray_a: assert property (!regRead |=> !regRdValid)
    else $error("stray read valid");
  mux_route_a: assert property (
    1 |=> routeDigital == $past(pinFunctionSelect))
    else $error("mux select not followed");
  gain_copy_a: assert property (
    1 |=> ampGainCode == $past(gainCode))
    else $error("gain code not followed");
  analog_off_a: assert property (
    !pinFunctionSelect[0] && !amplifierOutputEnable[0]
      |=> firstSenseOutPinOeN)
    else $error("analog buffer on while disabled");
  din_hiz_a: assert property (
    pinFunctionSelect[0] && !pinDriveEnable[0] |=> firstSenseOutPinOeN)
    else $error("pad driven without drive enable");
  amp_off_a: assert property (pinFunctionSelect[0] |=> ampHiZ[0])
    else $error("amplifier on in digital mode");
  dout_on_a: assert property (flagDirIn[0] |-> !firstSenseOutPinOeN)
    else $error("digital output not driven");
  analog_on_a: assert property (
    !firstSenseOutPinOeN && !routeDigital[0] |-> !ampHiZ[0])
    else $error("analog drive with amplifier off");
endmodule : aopfm_properties
bind aopfm_top aopfm_properties u_chk (.ref_clk, .rst, .regRead,
  .regRdValid, .pinFunctionSelect, .amplifierOutputEnable, .pinDriveEnable,
  .gainCode, .firstSenseOutPinOeN, .flagDirIn, .routeDigital, .ampHiZ,
  .ampGainCode);
`default_nettype wire

/* File: verification/aopfm_pad_model.sv */
`timescale 1ns/10ps
`default_nettype none
module aopfm_pad_model
(
  // pads from the block
  input  wire logic       firstSenseOutPinOut,
  input  wire logic       firstSenseOutPinOeN,
  input  wire logic       secondSenseOutPinOut,
  input  wire logic       secondSenseOutPinOeN,
  // host drive per pin
  input  wire logic [1:0] mcuEn,
  input  wire logic [1:0] mcuVal,
  // resolved pad levels
  output logic            firstSenseOutPinIn,
  output logic            secondSenseOutPinIn
);
  // pull-down wins when nobody drives
  assign firstSenseOutPinIn  = !firstSenseOutPinOeN ? firstSenseOutPinOut
                             : mcuEn[0] & mcuVal[0];
  assign secondSenseOutPinIn = !secondSenseOutPinOeN ? secondSenseOutPinOut
                             : mcuEn[1] & mcuVal[1];
endmodule : aopfm_pad_model
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import aopfm_pkg::*;
  logic        ref_clk = 0, rst = 1, regWrite = 0, regRead = 0;
  logic [8:0]  regAddr = '0;
  logic [15:0] regWrData = '0, regRdData;
  logic [1:0]  pinFunctionSelect = '0, amplifierOutputEnable = '0;
  logic [1:0]  pinDriveEnable = '0, flagDriveSignal = '0;
  logic [1:0]  mcuEn = '0, mcuVal = '0;
  logic [3:0]  gainCode = '0, ampGainCode;
  logic        regRdValid, firstSenseOutPinIn, firstSenseOutPinOut;
  logic        firstSenseOutPinOeN, secondSenseOutPinIn;
  logic        secondSenseOutPinOut, secondSenseOutPinOeN;
  logic [1:0]  flagIn, flagInValid, flagDirIn, routeDigital, ampHiZ;
  int          fail_count = 0, compares = 0;
  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;
  aopfm_top u_dut (.ref_clk, .rst, .regWrite, .regRead, .regAddr,
    .regWrData, .regRdData, .regRdValid, .pinFunctionSelect,
    .amplifierOutputEnable, .pinDriveEnable, .flagDriveSignal, .gainCode,
    .firstSenseOutPinIn, .firstSenseOutPinOut, .firstSenseOutPinOeN,
    .secondSenseOutPinIn, .secondSenseOutPinOut, .secondSenseOutPinOeN,
    .flagIn, .flagInValid, .flagDirIn, .routeDigital, .ampHiZ, .ampGainCode);
  aopfm_pad_model u_pad (.firstSenseOutPinOut, .firstSenseOutPinOeN,
    .secondSenseOutPinOut, .secondSenseOutPinOeN, .mcuEn, .mcuVal,
    .firstSenseOutPinIn, .secondSenseOutPinIn);
  // compare and bus helpers
  task automatic chk(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [15:0] pins();
    return {8'h00, firstSenseOutPinOeN, firstSenseOutPinOut,
            secondSenseOutPinOeN, secondSenseOutPinOut, flagDirIn, ampHiZ};
  endfunction : pins
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    regAddr = a;
    regWrData = d;
    regWrite = 1;
    @(negedge ref_clk) regWrite = 0;
    @(negedge ref_clk);
  endtask : wr
  task automatic rd(input logic [8:0] a, input logic [15:0] e);
    regAddr = a;
    regRead = 1;
    @(negedge ref_clk) regRead = 0;
    chk("rdValid", 16'h0001, {15'h0, regRdValid});
    chk("rdData", e, regRdData);
    @(negedge ref_clk);
  endtask : rd
  task automatic ctl(input logic [1:0] s, en, d);
    pinFunctionSelect = s;
    amplifierOutputEnable = en;
    pinDriveEnable = d;
    @(negedge ref_clk);
  endtask : ctl
  // scenarios
  task automatic t_reset;
    rd(FLAG_DIR_ADDR, FLAG_DIR_RST);
    rd(FLAG_ORIG_ADDR, FLAG_ORIG_RST);
    chk("pinsRst", 16'h00a3, pins());
  endtask : t_reset
  task automatic t_analog;
    ctl(2'h0, 2'h3, 2'h0);
    chk("analogOn", 16'h0000, pins());
    ctl(2'h0, 2'h0, 2'h3);
    chk("analogOff", 16'h00a3, pins());
  endtask : t_analog
  task automatic t_dout;
    wr(FLAG_ORIG_ADDR, 16'h0c00);
    flagDriveSignal = 2'h2;
    ctl(2'h3, 2'h3, 2'h3);
    chk("dout", 16'h001f, pins());
    chk("route", 16'h0003, {14'h0, routeDigital});
    ctl(2'h0, 2'h3, 2'h0);
    chk("orig1Sel0", 16'h00a3, pins());
  endtask : t_dout
  task automatic t_din;
    wr(FLAG_DIR_ADDR, 16'h0c00);
    ctl(2'h3, 2'h0, 2'h3);
    chk("dirInDrv", 16'h00a3, pins());
    mcuEn = 2'h2;
    mcuVal = 2'h2;
    ctl(2'h3, 2'h0, 2'h0);
    repeat (5) @(negedge ref_clk);
    chk("din", 16'h00a3, pins());
    chk("flagIn", 16'h0002, {14'h0, flagIn});
    chk("inValid", 16'h0003, {14'h0, flagInValid});
    rd(FLAG_DIR_ADDR, 16'h0c00);
    rd(9'h1c2, REG_RD_NONE);
    mcuEn = 2'h0;
  endtask : t_din
  // reset in mid-run clears written registers and pad state
  task automatic t_rerst;
    rst = 1;
    repeat (2) @(negedge ref_clk);
    rst = 0;
    rd(FLAG_DIR_ADDR, FLAG_DIR_RST);
    rd(FLAG_ORIG_ADDR, FLAG_ORIG_RST);
    chk("pinsRerst", 16'h00a3, pins());
    chk("inValidRerst", 16'h0000, {14'h0, flagInValid});
    chk("flagInRerst", 16'h0000, {14'h0, flagIn});
  endtask : t_rerst
  task automatic t_gain;
    for (int i = 0; i < 4; i++)
    begin
      gainCode = {i[1:0], i[1:0]};
      @(negedge ref_clk);
      chk("gain", {12'h0, i[1:0], i[1:0]}, {12'h0, ampGainCode});
    end
  endtask : t_gain
  task automatic stop_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // main sequence
  initial
  begin
    repeat (5) @(negedge ref_clk);
    rst = 0;
    t_reset;
    t_analog;
    t_dout;
    t_din;
    t_rerst;
    t_gain;
    stop_test;
  end
  // watchdog, far beyond the few dozen cycles the tests need
  initial
  begin
    #100us;
    fail_count++;
    stop_test;
  end
endmodule : testbench
`default_nettype wire
